// File: rtl/codt_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "codt_consts.svh"

module codt_core (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Instruction request
    input wire logic instr_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [7:0] operand2,
    input wire logic [15:0] instr_addr,
    // Processor state from the datapath
    input wire logic [15:0] index_pair,
    input wire logic [7:0] accum,
    // Interrupt request pin
    input wire logic irq_n,
    // Sequencer status
    output logic busy,
    output logic instr_done,
    output logic illegal_op,
    output logic halted,
    // Bus cycle presented this clock
    output codt_pkg::codt_kind_t cycle_kind,
    output logic bus_rd,
    output logic bus_wr,
    output logic [15:0] bus_addr,
    // Results
    output logic [15:0] stack_ptr,
    output logic [7:0] condition_flags_reg,
    output logic [15:0] prog_counter,
    output logic [2:0] bit_sel,
    output logic [7:0] bit_mask
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    codt_pkg::codt_state_t state;
    logic [`CODT_PAT_W-1:0] pat;
    logic [3:0] cnt;
    logic [7:0] op_hold;
    logic [15:0] ea;
    logic [15:0] pc;
    logic [7:0] vec_lo;
    logic step_ea;
    logic irq_s1;
    logic irq_s2;
    logic irq_s3;
    logic irq_level;

    logic dec_legal;
    logic [1:0] dec_length;
    logic [3:0] dec_cycles;
    logic [`CODT_PAT_W-1:0] dec_pattern;
    codt_pkg::codt_mode_t dec_mode;
    logic dec_ea_step;

    // ---------------------------------------------------------------
    // Opcode decoder
    // ---------------------------------------------------------------
    codt_decode u_decode (
        .opcode (opcode),
        .legal (dec_legal),
        .length (dec_length),
        .cycles (dec_cycles),
        .pattern (dec_pattern),
        .mode (dec_mode),
        .ea_step (dec_ea_step)
    );

    // ---------------------------------------------------------------
    // Interrupt pin synchroniser
    // ---------------------------------------------------------------

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_s1 <= 1'b1;
            irq_s2 <= 1'b1;
            irq_s3 <= 1'b1;
        end else begin
            irq_s1 <= irq_n;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
        end
    end

    // Filtered request level, active while the pin is low
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_level <= 1'b0;
        end else if (irq_s2 == irq_s3) begin
            irq_level <= ~irq_s3;
        end
    end

    // ---------------------------------------------------------------
    // Request acceptance and sequencing terms
    // ---------------------------------------------------------------
    wire is_idle = (state == codt_pkg::CODT_ST_IDLE);
    wire is_run = (state == codt_pkg::CODT_ST_RUN);
    wire accept = is_idle & instr_valid & dec_legal;
    wire reject = is_idle & instr_valid & ~dec_legal;
    wire last = is_run & (cnt == 4'h0);
    wire present = accept | (is_run & ~last);

    // Address of the instruction that follows this one
    wire [15:0] next_instr = instr_addr + {14'h0000, dec_length};

    // Signed branch offset, sign extended to 16 bits
    wire [15:0] rel_ext = {{8{operand1[7]}}, operand1};
    wire [15:0] branch_dest = next_instr + rel_ext;
    wire higher = ~(condition_flags_reg[`CODT_FLG_C] |
                    condition_flags_reg[`CODT_FLG_Z]);

    // Effective address by addressing mode
    wire [15:0] dir_addr = {`CODT_PAGE_ZERO, operand1};
    wire [15:0] ext_addr = {operand1, operand2};
    wire [15:0] next_ea = (dec_mode == codt_pkg::CODT_M_EXT) ? ext_addr :
                          dir_addr;

    // Bit number taken from the opcode
    wire [2:0] next_bit_sel =
        opcode[`CODT_BITSEL_MSB:`CODT_BITSEL_LSB];
    wire [7:0] next_bit_mask = 8'h01 << next_bit_sel;

    // Kind of the cycle to present next
    wire [`CODT_KIND_W-1:0] next_kind_bits = accept ?
        dec_pattern[`CODT_KIND_W-1:0] : pat[`CODT_KIND_W-1:0];
    wire codt_pkg::codt_kind_t next_kind = present ?
        codt_pkg::codt_kind_t'(next_kind_bits) : codt_pkg::CODT_K_NONE;

    // Pattern and count after presenting a cycle
    wire [`CODT_PAT_W-1:0] pat_src = accept ? dec_pattern : pat;
    wire [`CODT_PAT_W-1:0] next_pat = pat_src >> `CODT_KIND_W;
    wire [3:0] cnt_src = accept ? dec_cycles : cnt;
    wire [3:0] next_cnt = cnt_src - 4'h1;

    // Working pointers seen by the cycle about to be presented
    wire [15:0] pc_src = accept ? instr_addr : pc;
    wire [15:0] ea_src = accept ? next_ea : ea;
    wire [7:0] vec_src = accept ? `CODT_SOFT_VEC_LO : vec_lo;
    wire step_src = accept ? dec_ea_step : step_ea;

    // Cycle kind decode for the next presented cycle
    wire k_free = (next_kind == codt_pkg::CODT_K_FREE);
    wire k_prog = (next_kind == codt_pkg::CODT_K_PROG);
    wire k_read = (next_kind == codt_pkg::CODT_K_READ);
    wire k_write = (next_kind == codt_pkg::CODT_K_WRITE);
    wire k_push = (next_kind == codt_pkg::CODT_K_PUSH);
    wire k_vect = (next_kind == codt_pkg::CODT_K_VECT);

    // Free cycles read at the program counter without advancing it
    wire next_rd = k_free | k_prog | k_read | k_vect;
    wire next_wr = k_write | k_push;
    wire [15:0] vect_addr = {`CODT_PAGE_VECT, vec_src};
    wire [15:0] next_addr =
        k_vect ? vect_addr :
        (k_read | k_write) ? ea_src :
        k_push ? stack_ptr :
        (k_prog | k_free) ? pc_src : 16'h0000;

    // Opcode that completes on this edge
    wire fin_ixsp = last & (op_hold == `CODT_OP_IXSP);
    wire fin_wait = last & (op_hold == `CODT_OP_WAIT);
    wire fin_tap = last & (op_hold == `CODT_OP_TAP);
    wire fin_soft = last & (op_hold == `CODT_OP_SOFTINT);
    wire wake = (state == codt_pkg::CODT_ST_HALT) & irq_level;

    // ---------------------------------------------------------------
    // Sequencer state
    // ---------------------------------------------------------------

    // Idle, running an instruction, or halted awaiting an interrupt
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= codt_pkg::CODT_ST_IDLE;
        end else if (accept) begin
            state <= codt_pkg::CODT_ST_RUN;
        end else if (fin_wait) begin
            state <= codt_pkg::CODT_ST_HALT;
        end else if (last | wake) begin
            state <= codt_pkg::CODT_ST_IDLE;
        end
    end

    // Remaining cycles and the kinds still to come
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pat <= '0;
            cnt <= 4'h0;
        end else if (present) begin
            pat <= next_pat;
            cnt <= next_cnt;
        end
    end

    // Opcode and bit selection held for the instruction
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            op_hold <= 8'h00;
            bit_sel <= 3'h0;
            bit_mask <= 8'h00;
        end else if (accept) begin
            op_hold <= opcode;
            bit_sel <= next_bit_sel;
            bit_mask <= next_bit_mask;
        end
    end

    // ---------------------------------------------------------------
    // Working pointers
    // ---------------------------------------------------------------

    // Program fetch address advances on each program fetch only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pc <= 16'h0000;
        end else if (present) begin
            pc <= k_prog ? pc_src + 16'h0001 : pc_src;
        end
    end

    // Operand address; steps only for two-byte operand reads
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ea <= 16'h0000;
            step_ea <= 1'b0;
        end else if (present) begin
            ea <= (k_read & step_src) ? ea_src + 16'h0001 : ea_src;
            step_ea <= step_src;
        end
    end

    // Vector low byte: high byte at the even address, low one next
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            vec_lo <= `CODT_SOFT_VEC_LO;
        end else if (present) begin
            vec_lo <= k_vect ? vec_src + 8'h01 : vec_src;
        end
    end

    // ---------------------------------------------------------------
    // Architectural results
    // ---------------------------------------------------------------

    // Stack pointer: pushes decrement, index transfer reloads it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            stack_ptr <= `CODT_SP_RESET;
        end else if (fin_ixsp) begin
            stack_ptr <= index_pair - 16'h0001;
        end else if (present & k_push) begin
            stack_ptr <= stack_ptr - 16'h0001;
        end
    end

    // Condition flags; index transfer leaves them untouched
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            condition_flags_reg <= `CODT_FLG_RESET;
        end else if (fin_tap) begin
            condition_flags_reg <= accum;
        end else if (fin_wait) begin
            condition_flags_reg[`CODT_FLG_I] <= 1'b0;
        end else if (fin_soft) begin
            condition_flags_reg[`CODT_FLG_I] <= 1'b1;
        end
    end

    // Program counter at instruction boundaries; taken branch jumps
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prog_counter <= 16'h0000;
        end else if (accept) begin
            if ((dec_mode == codt_pkg::CODT_M_REL) & higher) begin
                prog_counter <= branch_dest;
            end else begin
                prog_counter <= next_instr;
            end
        end
    end

    // ---------------------------------------------------------------
    // Registered bus and status outputs
    // ---------------------------------------------------------------

    // One presented cycle per clock, free cycles shown as reads
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cycle_kind <= codt_pkg::CODT_K_NONE;
            bus_rd <= 1'b0;
            bus_wr <= 1'b0;
            bus_addr <= 16'h0000;
        end else begin
            cycle_kind <= next_kind;
            bus_rd <= next_rd;
            bus_wr <= next_wr;
            bus_addr <= next_addr;
        end
    end

    // Status pulses and levels
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            instr_done <= 1'b0;
            illegal_op <= 1'b0;
            halted <= 1'b0;
        end else begin
            busy <= present;
            instr_done <= last;
            illegal_op <= reject;
            halted <= fin_wait | ((state == codt_pkg::CODT_ST_HALT) &
                                  ~irq_level);
        end
    end

endmodule : codt_core

`default_nettype wire

// File: inc/codt_consts.svh
`ifndef CODT_CONSTS_SVH
`define CODT_CONSTS_SVH

// ---------------------------------------------------------------
// Opcodes handled by the decoder
// ---------------------------------------------------------------
`define CODT_OP_IXSP     8'h94
`define CODT_OP_WAIT     8'h8F
`define CODT_OP_BG_ENTRY 8'h82
`define CODT_OP_SOFTINT  8'h83
`define CODT_OP_MULT     8'h42
`define CODT_OP_DIV      8'h52
`define CODT_OP_DEC_ADJ  8'h72
`define CODT_OP_BR_HIGH  8'h22
`define CODT_OP_SUBC_IMM 8'hA2
`define CODT_OP_CMPX_DIR 8'hB3
`define CODT_OP_SETB1    8'h12
`define CODT_OP_LDIX_EXT 8'h32
`define CODT_OP_COM_DIR  8'h33
`define CODT_OP_TAP      8'h84

// ---------------------------------------------------------------
// Cycle counts and lengths
// ---------------------------------------------------------------
`define CODT_CYC_1  4'h1
`define CODT_CYC_2  4'h2
`define CODT_CYC_3  4'h3
`define CODT_CYC_5  4'h5
`define CODT_CYC_6  4'h6
`define CODT_CYC_11 4'hB
`define CODT_LEN_1  2'h1
`define CODT_LEN_2  2'h2
`define CODT_LEN_3  2'h3

// ---------------------------------------------------------------
// Fields, pages, vectors and reset values
// ---------------------------------------------------------------
`define CODT_BITSEL_LSB  1
`define CODT_BITSEL_MSB  3
`define CODT_FLG_C       0
`define CODT_FLG_Z       1
`define CODT_FLG_I       3
`define CODT_FLG_RESET   8'h68
`define CODT_SP_RESET    16'h00FF
`define CODT_PAGE_ZERO   8'h00
`define CODT_PAGE_VECT   8'hFF
`define CODT_SOFT_VEC_LO 8'hFC
`define CODT_KIND_W      3
`define CODT_PAT_W       33

`endif

// File: inc/codt_pkg.sv
package codt_pkg;

    // Bus cycle kinds, one per bus clock of an instruction
    typedef enum logic [2:0] {
        CODT_K_NONE,
        CODT_K_FREE,
        CODT_K_PROG,
        CODT_K_READ,
        CODT_K_WRITE,
        CODT_K_PUSH,
        CODT_K_VECT
    } codt_kind_t;

    // Operand addressing
    typedef enum logic [1:0] {
        CODT_M_INH,
        CODT_M_DIR,
        CODT_M_EXT,
        CODT_M_REL
    } codt_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {
        CODT_ST_IDLE,
        CODT_ST_RUN,
        CODT_ST_HALT
    } codt_state_t;

endpackage : codt_pkg

// File: rtl/codt_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "codt_consts.svh"

module codt_decode (
    // Opcode in
    input wire logic [7:0] opcode,
    // Decoded attributes
    output logic legal,
    output logic [1:0] length,
    output logic [3:0] cycles,
    output logic [`CODT_PAT_W-1:0] pattern,
    output codt_pkg::codt_mode_t mode,
    output logic ea_step
);
    localparam codt_pkg::codt_kind_t F = codt_pkg::CODT_K_FREE;
    localparam codt_pkg::codt_kind_t P = codt_pkg::CODT_K_PROG;
    localparam codt_pkg::codt_kind_t R = codt_pkg::CODT_K_READ;
    localparam codt_pkg::codt_kind_t W = codt_pkg::CODT_K_WRITE;
    localparam codt_pkg::codt_kind_t S = codt_pkg::CODT_K_PUSH;
    localparam codt_pkg::codt_kind_t V = codt_pkg::CODT_K_VECT;

    // Patterns hold the first cycle in the lowest kind field
    always_comb begin
        legal = 1'b1;
        length = `CODT_LEN_1;
        cycles = `CODT_CYC_1;
        pattern = '0;
        mode = codt_pkg::CODT_M_INH;
        ea_step = 1'b0;
        unique case (opcode)
            `CODT_OP_IXSP, `CODT_OP_WAIT: begin
                cycles = `CODT_CYC_2;
                pattern = `CODT_PAT_W'({P, F});
            end
            `CODT_OP_BG_ENTRY: begin
                cycles = `CODT_CYC_5;
                pattern = `CODT_PAT_W'({P, F, F, F, F});
            end
            `CODT_OP_SOFTINT: begin
                cycles = `CODT_CYC_11;
                pattern = {P, P, P, F, V, V, S, S, S, S, S};
            end
            `CODT_OP_MULT: begin
                cycles = `CODT_CYC_5;
                pattern = `CODT_PAT_W'({P, F, F, F, F});
            end
            `CODT_OP_DIV: begin
                cycles = `CODT_CYC_6;
                pattern = `CODT_PAT_W'({P, F, F, F, F, F});
            end
            `CODT_OP_DEC_ADJ, `CODT_OP_TAP: begin
                cycles = `CODT_CYC_1;
                pattern = `CODT_PAT_W'(P);
            end
            `CODT_OP_BR_HIGH: begin
                length = `CODT_LEN_2;
                cycles = `CODT_CYC_3;
                mode = codt_pkg::CODT_M_REL;
                pattern = `CODT_PAT_W'({P, P, P});
            end
            `CODT_OP_SUBC_IMM: begin
                length = `CODT_LEN_2;
                cycles = `CODT_CYC_2;
                pattern = `CODT_PAT_W'({P, P});
            end
            `CODT_OP_CMPX_DIR: begin
                length = `CODT_LEN_2;
                cycles = `CODT_CYC_3;
                mode = codt_pkg::CODT_M_DIR;
                pattern = `CODT_PAT_W'({P, P, R});
            end
            `CODT_OP_SETB1, `CODT_OP_COM_DIR: begin
                length = `CODT_LEN_2;
                cycles = `CODT_CYC_5;
                mode = codt_pkg::CODT_M_DIR;
                pattern = `CODT_PAT_W'({P, P, W, F, R});
            end
            `CODT_OP_LDIX_EXT: begin
                length = `CODT_LEN_3;
                cycles = `CODT_CYC_5;
                mode = codt_pkg::CODT_M_EXT;
                ea_step = 1'b1;
                pattern = `CODT_PAT_W'({P, P, R, R, P});
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

endmodule : codt_decode

`default_nettype wire

// File: test/codt_core_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Sequencer checker
// ---------------------------------------------------------------
module codt_core_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Request side
    input wire logic instr_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] operand1,
    input wire logic [15:0] instr_addr,
    input wire logic [15:0] index_pair,
    input wire logic [7:0] accum,
    // Status and bus
    input wire logic busy,
    input wire logic instr_done,
    input wire logic illegal_op,
    input wire logic halted,
    input wire codt_pkg::codt_kind_t cycle_kind,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [15:0] bus_addr,
    // Results
    input wire logic [7:0] condition_flags_reg,
    input wire logic [15:0] stack_ptr,
    input wire logic [15:0] prog_counter,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] bit_mask
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Expected cycles, zero if undecoded
    function automatic logic [3:0] ecyc(input logic [7:0] op);
        case (op)
            8'h72, 8'h84: ecyc = 4'h1;
            8'h94, 8'h8F, 8'hA2: ecyc = 4'h2;
            8'h22, 8'hB3: ecyc = 4'h3;
            8'h82, 8'h42, 8'h12, 8'h32, 8'h33: ecyc = 4'h5;
            8'h52: ecyc = 4'h6;
            8'h83: ecyc = 4'hB;
            default: ecyc = 4'h0;
        endcase
    endfunction : ecyc

    // Request taken, bus kinds, branch target
    wire take = instr_valid && !busy && !halted;
    wire k_free = cycle_kind == codt_pkg::CODT_K_FREE;
    wire k_prog = cycle_kind == codt_pkg::CODT_K_PROG;
    wire k_vect = cycle_kind == codt_pkg::CODT_K_VECT;
    wire k_rw = cycle_kind == codt_pkg::CODT_K_READ ||
        cycle_kind == codt_pkg::CODT_K_WRITE;
    wire hi = !condition_flags_reg[0] && !condition_flags_reg[1];
    wire [15:0] rel = hi ? {{8{operand1[7]}}, operand1} : 16'h0000;
    logic [3:0] cnt;
    logic [3:0] exp_n;
    logic [7:0] op_l;
    logic [15:0] pc_exp;
    logic [15:0] dir_a;

    // Latch the request and count presented cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            exp_n <= 4'h0;
            op_l <= 8'h00;
            pc_exp <= 16'h0000;
            dir_a <= 16'h0000;
        end else if (take) begin
            cnt <= 4'h0;
            exp_n <= ecyc(opcode);
            op_l <= opcode;
            pc_exp <= instr_addr + 16'h0002 + rel;
            dir_a <= {8'h00, operand1};
        end else if (busy) begin
            cnt <= cnt + 4'h1;
        end
    end

    AST_FREE_RD: assert property (
        k_free |-> bus_rd && !bus_wr)
        else $error("free cycle");
    AST_VECT_PAGE: assert property (
        k_vect |-> bus_addr[15:8] == 8'hFF)
        else $error("vector page");
    AST_VECT_ORDER: assert property (
        k_vect && !$past(k_vect) |=>
        k_vect && bus_addr == $past(bus_addr) + 16'h0001)
        else $error("vector order");
    AST_CYC_LONG: assert property (
        instr_done && exp_n >= 4'h5 |-> cnt == exp_n)
        else $error("long count");
    AST_CYC_SHORT: assert property (
        instr_done && exp_n < 4'h5 |-> cnt == exp_n)
        else $error("short count");
    AST_TXS: assert property (
        take && opcode == 8'h94 |=> k_free ##1 k_prog ##1 instr_done &&
        stack_ptr == $past(index_pair) - 16'h0001 &&
        $stable(condition_flags_reg))
        else $error("stack load");
    AST_WAIT: assert property (
        take && opcode == 8'h8F |=> k_free ##1 k_prog ##[1:2]
        (halted && !condition_flags_reg[3]))
        else $error("wait halt");
    AST_ILLEGAL: assert property (
        take && ecyc(opcode) == 4'h0 |=> illegal_op && !busy ##1
        !illegal_op && !busy)
        else $error("illegal op");
    AST_DIR_PAGE: assert property (
        k_rw && op_l != 8'h32 |-> bus_addr == dir_a)
        else $error("direct page");
    AST_BRANCH: assert property (
        instr_done && op_l == 8'h22 |-> prog_counter == pc_exp)
        else $error("branch dest");
    AST_TAP: assert property (
        instr_done && op_l == 8'h84 |-> condition_flags_reg == $past(accum))
        else $error("flag load");
    AST_BITSEL: assert property (
        instr_done && op_l == 8'h12 |-> bit_sel == 3'h1 && bit_mask == 8'h02)
        else $error("bit select");

    // Main scenarios reached
    cover property (take && opcode == 8'h83);
    cover property (illegal_op);
    cover property ($fell(halted));
    cover property (instr_done && op_l == 8'h22);
endmodule : codt_core_checker

bind codt_core codt_core_checker u_chk (.mclk, .reset_n, .instr_valid, .opcode,
    .operand1, .instr_addr, .index_pair, .accum, .busy, .instr_done, .illegal_op,
    .halted, .cycle_kind, .bus_rd, .bus_wr, .bus_addr, .condition_flags_reg,
    .stack_ptr, .prog_counter, .bit_sel, .bit_mask);

`default_nettype wire

// File: test/codt_irq_model.sv
`timescale 1ns/10ps
`default_nettype none

// ---------------------------------------------------------------
// Interrupt source on the far side
// ---------------------------------------------------------------
module codt_irq_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Wake request from the bench
    input wire logic wake,
    // Interrupt pin, idles high
    output logic irq_n
);
    logic [2:0] hold;

    // Hold the pin low through the sync
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hold <= 3'h0;
        end else if (wake) begin
            hold <= 3'h6;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    assign irq_n = hold == 3'h0;
endmodule : codt_irq_model

`default_nettype wire

// File: test/cpu_opcode_decode_timing_test.sv
`timescale 1ns/10ps
`default_nettype none

module cpu_opcode_decode_timing_test;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] op;
        logic [7:0] o1;
        logic [15:0] addr;
        logic [3:0] cyc;
        logic [15:0] pc;
    } codt_row_t;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [7:0] operand1 = 8'h00;
    logic [7:0] operand2 = 8'h34;
    logic [15:0] instr_addr = 16'h0000;
    logic [15:0] index_pair = 16'h0200;
    logic [7:0] accum = 8'h68;
    logic wake = 1'b0;
    wire logic irq_n;
    logic busy, instr_done, illegal_op, halted, bus_rd, bus_wr;
    codt_pkg::codt_kind_t cycle_kind;
    logic [15:0] bus_addr, stack_ptr, prog_counter;
    logic [7:0] condition_flags_reg;
    logic [2:0] bit_sel;
    int bad_count = 0;
    int compares = 0;
    int n;
    logic [15:0] vq[$];
    codt_row_t rows[13];

    always #10 mclk = ~mclk;

    codt_irq_model u_irq (.mclk, .reset_n, .wake, .irq_n);

    codt_core u_dut (.mclk, .reset_n, .instr_valid, .opcode, .operand1,
        .operand2, .instr_addr, .index_pair, .accum, .irq_n, .busy,
        .instr_done, .illegal_op, .halted, .cycle_kind, .bus_rd, .bus_wr,
        .bus_addr, .stack_ptr, .condition_flags_reg, .prog_counter,
        .bit_sel, .bit_mask());

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic chk(input string what, input logic [15:0] exp, got);
        compares++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic end_of_test;
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // Issue a request, count busy cycles
    task automatic run(input logic [7:0] op, o1, input logic [15:0] a);
        int k;
        operand1 = o1;
        instr_addr = a;
        poke(op);
        n = 0;
        k = 0;
        vq = {};
        while (instr_done !== 1'b1 && halted !== 1'b1) begin
            if (busy === 1'b1) n++;
            if (cycle_kind === codt_pkg::CODT_K_VECT) vq.push_back(bus_addr);
            k++;
            if (k > 30) begin
                bad_count++;
                end_of_test;
            end
            tick;
        end
    endtask : run

    // One-edge request
    task automatic poke(input logic [7:0] op);
        opcode = op;
        instr_valid = 1'b1;
        tick;
        instr_valid = 1'b0;
    endtask : poke

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        // Rows: opcode, operand, address, cycles, next pc
        rows = '{52'h94_00_0100_2_0101, 52'h82_00_0110_5_0111,
            52'h42_00_0120_5_0121, 52'h52_00_0130_6_0131,
            52'h72_00_0140_1_0141, 52'h84_00_0150_1_0151,
            52'h22_80_0200_3_0182, 52'h22_7F_0210_3_0291,
            52'hA2_55_0220_2_0222, 52'hB3_40_0230_3_0232,
            52'h12_41_0240_5_0242, 52'h32_12_0250_5_0253,
            52'h33_42_0260_5_0262};
        repeat (5) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        chk("stack_ptr", 16'h00FF, stack_ptr);
        chk("flags", 16'h0068, {8'h00, condition_flags_reg});
        for (int i = 0; i < 13; i++) begin
            run(rows[i].op, rows[i].o1, rows[i].addr);
            chk("cycles", {12'h000, rows[i].cyc}, 16'(n));
            chk("prog_counter", rows[i].pc, prog_counter);
        end
        chk("stack_ptr", 16'h01FF, stack_ptr);
        chk("flags", 16'h0068, {8'h00, condition_flags_reg});
        // Carry set, branch falls through
        accum = 8'h01;
        run(8'h84, 8'h00, 16'h0300);
        chk("flags", 16'h0001, {8'h00, condition_flags_reg});
        run(8'h22, 8'h10, 16'h0310);
        chk("prog_counter", 16'h0312, prog_counter);
        // Software interrupt
        run(8'h83, 8'h00, 16'h0320);
        chk("cycles", 16'h000B, 16'(n));
        chk("vector_high", 16'hFFFC, vq[0]);
        chk("vector_low", 16'hFFFD, vq[1]);
        chk("stack_ptr", 16'h01FA, stack_ptr);
        chk("mask", 16'h0001, {15'h0000, condition_flags_reg[3]});
        // Wait, refused request, wake
        run(8'h8F, 8'h00, 16'h0330);
        chk("cycles", 16'h0002, 16'(n));
        chk("halted", 16'h0001, {15'h0000, halted});
        chk("mask", 16'h0000, {15'h0000, condition_flags_reg[3]});
        poke(8'h72);
        chk("busy", 16'h0000, {15'h0000, busy});
        wake = 1'b1;
        tick;
        wake = 1'b0;
        n = 0;
        while (halted === 1'b1 && n < 12) begin
            tick;
            n++;
        end
        chk("halted", 16'h0000, {15'h0000, halted});
        if (halted !== 1'b0) end_of_test;
        // Undecoded opcode, then a request
        poke(8'h00);
        chk("illegal_op", 16'h0001, {15'h0000, illegal_op});
        chk("busy", 16'h0000, {15'h0000, busy});
        tick;
        run(8'hA2, 8'h01, 16'h0340);
        chk("cycles", 16'h0002, 16'(n));
        // Reset in mid instruction
        poke(8'h52);
        tick;
        reset_n = 1'b0;
        tick;
        reset_n = 1'b1;
        chk("stack_ptr", 16'h00FF, stack_ptr);
        chk("busy", 16'h0000, {15'h0000, busy});
        run(8'hB3, 8'h20, 16'h0400);
        chk("cycles", 16'h0003, 16'(n));
        end_of_test;
    end
endmodule : cpu_opcode_decode_timing_test

`default_nettype wire
